/* File: hdl/ppq_pkg.sv */
// package: register map, field layout and reset values of the ptp priority and queue map block
package ppq_pkg;
    // ==========================================
    // register word indices; byte address = 4 * index
    localparam logic [11:0] PPQ_IDX_EVENT = 12'h37C;
    localparam logic [11:0] PPQ_IDX_NONEVENT = 12'h37D;
    localparam logic [11:0] PPQ_IDX_QUEUE = 12'h390;
    localparam int PPQ_ADDR_W = 12;
    // ==========================================
    // field positions
    localparam int PPQ_OVR_BIT = 7;
    localparam int PPQ_PRIO_MSB = 3;
    localparam int PPQ_MAP_MSB = 7;
    localparam int PPQ_MAP_LSB = 6;
    localparam int PPQ_MEMB_BIT = 1;
    localparam int PPQ_QRSV_MSB = 5;
    localparam int PPQ_QRSV_LSB = 2;
    localparam int PPQ_QRSV0_BIT = 0;
    // ==========================================
    // reset values
    localparam logic PPQ_OVR_RST = 1'h0;
    localparam logic [3:0] PPQ_PRIO_RST = 4'hF;
    localparam logic [1:0] PPQ_MAP_RST = 2'h2;
    localparam logic PPQ_MEMB_RST = 1'h1;
    localparam logic [3:0] PPQ_QRSV_RST = 4'h0;
    // ==========================================
    // two-queue map codes
    localparam logic [1:0] PPQ_MAP_P3 = 2'h0;
    localparam logic [1:0] PPQ_MAP_P23 = 2'h2;
    localparam logic [1:0] PPQ_MAP_P123 = 2'h3;
    // ==========================================
    // frame classes
    typedef enum logic [1:0] {PPQ_CLS_OTHER, PPQ_CLS_EVENT, PPQ_CLS_NONEVENT} ppq_class_t;
endpackage : ppq_pkg

/* File: hdl/ppq_cfg_if.sv */
// interface: configuration fields handed from the register bank to the frame decision logic
`timescale 1ns/100ps
`default_nettype none
interface ppq_cfg_if;
    logic ev_ovr;
    logic [3:0] ev_prio;
    logic ne_ovr;
    logic [3:0] ne_prio;
    logic [1:0] two_queue_priority_map;
    logic memb_discard;
    modport bank (output ev_ovr, ev_prio, ne_ovr, ne_prio, two_queue_priority_map, memb_discard);
    modport user (input ev_ovr, ev_prio, ne_ovr, ne_prio, two_queue_priority_map, memb_discard);
endinterface : ppq_cfg_if
`default_nettype wire

/* File: hdl/ppq_decide.sv */
// frame decision: ptp priority override, two-queue mapping, membership restriction
`timescale 1ns/100ps
`default_nettype none
module ppq_decide
    import ppq_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // configuration
    ppq_cfg_if.user cfg,
    // frame request
    input wire logic frm_valid_i,
    input wire ppq_pkg::ppq_class_t frm_class_i,
    input wire logic [3:0] frm_qos_prio_i,
    input wire logic [1:0] frm_regen_prio_i,
    input wire logic frm_single_dest_i,
    input wire logic frm_mirrored_i,
    input wire logic mirror_en_i,
    input wire logic [6:0] frm_dest_map_i,
    input wire logic [6:0] frm_memb_map_i,
    // decision
    output logic dec_valid_o,
    output logic [3:0] dec_prio_o,
    output logic dec_high_queue_o,
    output logic [6:0] dec_fwd_map_o,
    output logic dec_drop_o
);
    logic [3:0] prio_next;
    logic high_next;
    logic [6:0] fwd_next;
    logic drop_next;
    logic restrict_c;

    // ==========================================
    // priority choice
    always_comb
    begin
        prio_next = frm_qos_prio_i;
        case (frm_class_i)
            PPQ_CLS_EVENT:
            begin
                if (cfg.ev_ovr)
                begin
                    prio_next = cfg.ev_prio;
                end
            end
            PPQ_CLS_NONEVENT:
            begin
                if (cfg.ne_ovr)
                begin
                    prio_next = cfg.ne_prio;
                end
            end
            default:
            begin
                prio_next = frm_qos_prio_i;
            end
        endcase
    end

    // ==========================================
    // two-queue mapping; code 01 undefined, treated like reset map
    always_comb
    begin
        case (cfg.two_queue_priority_map)
            PPQ_MAP_P3: high_next = (frm_regen_prio_i == 2'h3);
            PPQ_MAP_P123: high_next = (frm_regen_prio_i != 2'h0);
            default: high_next = frm_regen_prio_i[1];
        endcase
    end

    // ==========================================
    // membership restriction
    always_comb
    begin
        restrict_c = cfg.memb_discard || !frm_single_dest_i;
        fwd_next = restrict_c ? (frm_dest_map_i & frm_memb_map_i) : frm_dest_map_i;
        drop_next = !cfg.memb_discard && frm_single_dest_i && mirror_en_i && frm_mirrored_i;
        if (drop_next)
        begin
            fwd_next = 7'h00;
        end
    end

    // ==========================================
    // registered decision, one cycle after the request
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            dec_valid_o <= 1'b0;
            dec_prio_o <= 4'h0;
            dec_high_queue_o <= 1'b0;
            dec_fwd_map_o <= 7'h00;
            dec_drop_o <= 1'b0;
        end
        else
        begin
            dec_valid_o <= frm_valid_i;
            dec_prio_o <= prio_next;
            dec_high_queue_o <= high_next;
            dec_fwd_map_o <= fwd_next;
            dec_drop_o <= drop_next && frm_valid_i;
        end
    end
endmodule : ppq_decide
`default_nettype wire

/* File: hdl/ppq_top.sv */
// top: avalon-mm register bank for ptp priority override and queue mapping
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ppq_top
    import ppq_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [13:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // frame request
    input wire logic frm_valid_i,
    input wire ppq_pkg::ppq_class_t frm_class_i,
    input wire logic [3:0] frm_qos_prio_i,
    input wire logic [1:0] frm_regen_prio_i,
    input wire logic frm_single_dest_i,
    input wire logic frm_mirrored_i,
    input wire logic mirror_en_i,
    input wire logic [6:0] frm_dest_map_i,
    input wire logic [6:0] frm_memb_map_i,
    // decision
    output logic dec_valid_o,
    output logic [3:0] dec_prio_o,
    output logic dec_high_queue_o,
    output logic [6:0] dec_fwd_map_o,
    output logic dec_drop_o
);
    import ppq_pkg::*;

    logic ev_ovr_reg;
    logic [3:0] ev_prio_reg;
    logic ne_ovr_reg;
    logic [3:0] ne_prio_reg;
    logic [1:0] map_reg;
    logic memb_reg;
    logic [3:0] qrsv_reg;
    logic qrsv0_reg;
    logic ack_reg;
    logic [31:0] rdata_next;
    logic [PPQ_ADDR_W-1:0] idx;
    logic req;
    logic wr_go;

    ppq_cfg_if cfg ();

    // ==========================================
    // bus decode: word index from byte address
    assign idx = avs_address_i[13:2];
    assign req = (avs_read_i || avs_write_i) && !ack_reg;
    assign wr_go = avs_write_i && !ack_reg;

    // one wait cycle: answer taken at the second edge of each request
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= req;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            avs_waitrequest_o <= !req;
        end
    end

    // ==========================================
    // event priority register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ev_ovr_reg <= PPQ_OVR_RST;
            ev_prio_reg <= PPQ_PRIO_RST;
        end
        else if (wr_go && idx == PPQ_IDX_EVENT && avs_byteenable_i[0])
        begin
            ev_ovr_reg <= avs_writedata_i[PPQ_OVR_BIT];
            ev_prio_reg <= avs_writedata_i[PPQ_PRIO_MSB:0];
        end
    end

    // ==========================================
    // non-event priority register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ne_ovr_reg <= PPQ_OVR_RST;
            ne_prio_reg <= PPQ_PRIO_RST;
        end
        else if (wr_go && idx == PPQ_IDX_NONEVENT && avs_byteenable_i[0])
        begin
            ne_ovr_reg <= avs_writedata_i[PPQ_OVR_BIT];
            ne_prio_reg <= avs_writedata_i[PPQ_PRIO_MSB:0];
        end
    end

    // ==========================================
    // queue management register; bits 5:2 and 0 are plain storage
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            map_reg <= PPQ_MAP_RST;
            memb_reg <= PPQ_MEMB_RST;
            qrsv_reg <= PPQ_QRSV_RST;
            qrsv0_reg <= 1'b0;
        end
        else if (wr_go && idx == PPQ_IDX_QUEUE && avs_byteenable_i[0])
        begin
            map_reg <= avs_writedata_i[PPQ_MAP_MSB:PPQ_MAP_LSB];
            memb_reg <= avs_writedata_i[PPQ_MEMB_BIT];
            qrsv_reg <= avs_writedata_i[PPQ_QRSV_MSB:PPQ_QRSV_LSB];
            qrsv0_reg <= avs_writedata_i[PPQ_QRSV0_BIT];
        end
    end

    // ==========================================
    // read mux; unmapped words read zero
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (idx)
            PPQ_IDX_EVENT:
            begin
                rdata_next[PPQ_OVR_BIT] = ev_ovr_reg;
                rdata_next[PPQ_PRIO_MSB:0] = ev_prio_reg;
            end
            PPQ_IDX_NONEVENT:
            begin
                rdata_next[PPQ_OVR_BIT] = ne_ovr_reg;
                rdata_next[PPQ_PRIO_MSB:0] = ne_prio_reg;
            end
            PPQ_IDX_QUEUE:
            begin
                rdata_next[PPQ_MAP_MSB:PPQ_MAP_LSB] = map_reg;
                rdata_next[PPQ_QRSV_MSB:PPQ_QRSV_LSB] = qrsv_reg;
                rdata_next[PPQ_MEMB_BIT] = memb_reg;
                rdata_next[PPQ_QRSV0_BIT] = qrsv0_reg;
            end
            default:
            begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            avs_readdata_o <= 32'h0000_0000;
        end
        else if (avs_read_i && !ack_reg)
        begin
            avs_readdata_o <= rdata_next;
        end
    end

    // ==========================================
    // configuration hand-off
    assign cfg.ev_ovr = ev_ovr_reg;
    assign cfg.ev_prio = ev_prio_reg;
    assign cfg.ne_ovr = ne_ovr_reg;
    assign cfg.ne_prio = ne_prio_reg;
    assign cfg.two_queue_priority_map = map_reg;
    assign cfg.memb_discard = memb_reg;

    ppq_decide u_decide (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cfg(cfg),
        .frm_valid_i(frm_valid_i),
        .frm_class_i(frm_class_i),
        .frm_qos_prio_i(frm_qos_prio_i),
        .frm_regen_prio_i(frm_regen_prio_i),
        .frm_single_dest_i(frm_single_dest_i),
        .frm_mirrored_i(frm_mirrored_i),
        .mirror_en_i(mirror_en_i),
        .frm_dest_map_i(frm_dest_map_i),
        .frm_memb_map_i(frm_memb_map_i),
        .dec_valid_o(dec_valid_o),
        .dec_prio_o(dec_prio_o),
        .dec_high_queue_o(dec_high_queue_o),
        .dec_fwd_map_o(dec_fwd_map_o),
        .dec_drop_o(dec_drop_o)
    );
endmodule : ppq_top
`default_nettype wire

/* File: tb/ppq_assertions.sv */
// checker: bus handshake and frame decision properties of the ptp priority block
`timescale 1ns/100ps
`default_nettype none
module ppq_assertions
    import ppq_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // register bus
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    // frame request and decision
    input wire logic frm_valid_i,
    input wire ppq_pkg::ppq_class_t frm_class_i,
    input wire logic [3:0] frm_qos_prio_i,
    input wire logic frm_single_dest_i,
    input wire logic mirror_en_i,
    input wire logic [6:0] frm_dest_map_i,
    input wire logic [6:0] frm_memb_map_i,
    input wire logic dec_valid_o,
    input wire logic [3:0] dec_prio_o,
    input wire logic [6:0] dec_fwd_map_o,
    input wire logic dec_drop_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // bus
    bus_answer_a: assert property ($rose(avs_read_i) || $rose(avs_write_i) |=> !avs_waitrequest_o)
        else $error("no answer one cycle after request");
    ack_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer longer than one cycle");
    // ==========================================
    // frame decision
    valid_follow_a: assert property (frm_valid_i |=> dec_valid_o)
        else $error("decision not one cycle after request");
    idle_quiet_a: assert property (!frm_valid_i |=> !dec_valid_o && !dec_drop_o)
        else $error("decision without request");
    drop_clear_a: assert property (dec_drop_o |-> dec_valid_o && dec_fwd_map_o == 7'h00)
        else $error("drop with nonzero forward map");
    no_mirror_a: assert property (frm_valid_i && !mirror_en_i |=> !dec_drop_o)
        else $error("drop while mirroring off");
    multi_dest_a: assert property (frm_valid_i && !frm_single_dest_i |=>
        dec_fwd_map_o == ($past(frm_dest_map_i) & $past(frm_memb_map_i)))
        else $error("multi destination frame not confined");
    other_prio_a: assert property (frm_valid_i && frm_class_i == PPQ_CLS_OTHER |=>
        dec_prio_o == $past(frm_qos_prio_i))
        else $error("non ptp frame priority changed");
endmodule : ppq_assertions
bind ppq_top ppq_assertions chk_u (.mclk_i, .rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
    .frm_valid_i, .frm_class_i, .frm_qos_prio_i, .frm_single_dest_i, .mirror_en_i, .frm_dest_map_i,
    .frm_memb_map_i, .dec_valid_o, .dec_prio_o, .dec_fwd_map_o, .dec_drop_o);
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench: register bank and frame decision scenarios
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ppq_pkg::*;
    logic mclk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o, dec_valid_o;
    logic [13:0] avs_address_i = 0;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o;
    logic [3:0] avs_byteenable_i = 0, frm_qos_prio_i = 0, dec_prio_o;
    logic frm_valid_i = 0, frm_single_dest_i = 0, frm_mirrored_i = 0, mirror_en_i = 0;
    logic dec_high_queue_o, dec_drop_o;
    ppq_class_t frm_class_i = PPQ_CLS_OTHER;
    logic [1:0] frm_regen_prio_i = 0;
    logic [6:0] frm_dest_map_i = 0, frm_memb_map_i = 0, dec_fwd_map_o;
    int n_errors = 0, n_tests = 0;
    localparam logic [13:0] EV = {PPQ_IDX_EVENT, 2'h0}, NE = {PPQ_IDX_NONEVENT, 2'h0}, QM = {PPQ_IDX_QUEUE, 2'h0};
    ppq_top dut_u (.mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .frm_valid_i, .frm_class_i, .frm_qos_prio_i,
        .frm_regen_prio_i, .frm_single_dest_i, .frm_mirrored_i, .mirror_en_i, .frm_dest_map_i,
        .frm_memb_map_i, .dec_valid_o, .dec_prio_o, .dec_high_queue_o, .dec_fwd_map_o, .dec_drop_o);
    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end
    // ==========================================
    // shared tasks
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] wd, input logic [3:0] be,
        output logic [31:0] rd);
        int i;
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        i = 0;
        do
        begin
            @(posedge mclk_i);
            i++;
        end
        while (avs_waitrequest_o !== 1'b0 && i < 20);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0)
        begin
            n_errors++;
            give_verdict();
        end
    endtask : bus
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        logic [31:0] x;
        bus(1'b1, a, d, be, x);
    endtask : wr
    task automatic rd_chk(input string what, input logic [13:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, 4'hF, d);
        check(what, exp, d);
    endtask : rd_chk
    task automatic frame(input ppq_class_t c, input logic [3:0] q, input logic [1:0] r, input logic [2:0] f);
        @(posedge mclk_i);
        frm_valid_i <= 1'b1;
        frm_class_i <= c;
        frm_qos_prio_i <= q;
        frm_regen_prio_i <= r;
        {frm_single_dest_i, frm_mirrored_i, mirror_en_i} <= f;
        frm_dest_map_i <= 7'h5A;
        frm_memb_map_i <= 7'h0F;
        @(posedge mclk_i);
        frm_valid_i <= 1'b0;
        #1;
        check("dec_valid", 32'h1, {31'h0, dec_valid_o});
    endtask : frame
    task automatic prio_case(input ppq_class_t c, input logic [3:0] exp);
        frame(c, 4'h9, 2'h0, 3'h0);
        check("dec_prio", {28'h0, exp}, {28'h0, dec_prio_o});
    endtask : prio_case
    task automatic memb_case(input logic disc, input logic [2:0] f, input logic [6:0] fwd, input logic drop);
        wr(QM, {24'h0, 2'h2, 4'h0, disc, 1'b0});
        frame(PPQ_CLS_OTHER, 4'h0, 2'h0, f);
        check("dec_fwd_map", {25'h0, fwd}, {25'h0, dec_fwd_map_o});
        check("dec_drop", {31'h0, drop}, {31'h0, dec_drop_o});
    endtask : memb_case
    // ==========================================
    // scenarios
    task automatic s_reset;
        rd_chk("event reg", EV, 32'h0F);
        rd_chk("nonevent reg", NE, 32'h0F);
        rd_chk("queue reg", QM, 32'h82);
    endtask : s_reset
    task automatic s_regs;
        wr(EV, 32'hFA);
        rd_chk("event reg", EV, 32'h8A);
        wr(EV, 32'h05, 4'hE);
        rd_chk("event masked", EV, 32'h8A);
        wr(14'h0000, 32'hFF);
        rd_chk("unmapped", 14'h0000, 32'h0);
        wr(QM, 32'hFFFFFFFF);
        rd_chk("queue reg", QM, 32'hFF);
    endtask : s_regs
    task automatic s_prio;
        prio_case(PPQ_CLS_EVENT, 4'hA);
        prio_case(PPQ_CLS_NONEVENT, 4'h9);
        wr(NE, 32'h8C);
        prio_case(PPQ_CLS_NONEVENT, 4'hC);
        prio_case(PPQ_CLS_OTHER, 4'h9);
        wr(EV, 32'h03);
        prio_case(PPQ_CLS_EVENT, 4'h9);
    endtask : s_prio
    task automatic s_map;
        logic exp_hq;
        for (int m = 0; m < 4; m++)
        begin
            wr(QM, {24'h0, m[1:0], 6'h02});
            for (int r = 0; r < 4; r++)
            begin
                frame(PPQ_CLS_OTHER, 4'h0, r[1:0], 3'h0);
                exp_hq = (m == 0) ? (r == 3) : (m == 3) ? (r != 0) : r[1];
                check("high queue", {31'h0, exp_hq}, {31'h0, dec_high_queue_o});
            end
        end
    endtask : s_map
    task automatic s_memb;
        memb_case(1'b1, 3'h4, 7'h0A, 1'b0);
        memb_case(1'b1, 3'h7, 7'h0A, 1'b0);
        memb_case(1'b0, 3'h4, 7'h5A, 1'b0);
        memb_case(1'b0, 3'h5, 7'h5A, 1'b0);
        memb_case(1'b0, 3'h1, 7'h0A, 1'b0);
        memb_case(1'b0, 3'h7, 7'h00, 1'b1);
        memb_case(1'b0, 3'h6, 7'h5A, 1'b0);
    endtask : s_memb
    initial
    begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        s_reset();
        s_regs();
        s_prio();
        s_map();
        s_memb();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
